// file: clock_mux_pkg.sv
// Shared constants and types for the glitch-free global clock selector bank
package clock_mux_pkg;

	// Number of independent selector channels in the bank
	localparam int NUM_BUFS = 16;
	// Most global clocks one quadrant may receive
	localparam int QUAD_LIMIT = 8;

	// Per-channel inputs from the driving logic
	typedef struct packed {
		logic src0; // Clock input 0 (also the gated-buffer input)
		logic src1; // Clock input 1
		logic sel;  // Source select, mux mode
		logic ce;   // Clock enable, gated-buffer mode
	} chan_in_t;

	// Path state of one channel
	typedef enum logic {
		ST_RUN,
		ST_PARK
	} path_state_t;

	// Values after reset
	localparam path_state_t STATE_RESET = ST_PARK;
	localparam logic SRC_RESET = 1'h0;

endpackage : clock_mux_pkg

// file: glitch_free_clock_selector.sv
// Bank of glitch-free 2:1 clock selectors, each also usable as a gated clock driver
`timescale 1ns/100ps

module glitch_free_clock_selector #(
	parameter int NUM_BUFS = clock_mux_pkg::NUM_BUFS,
	parameter logic [NUM_BUFS-1:0] STOP_HIGH = '0,
	parameter logic [NUM_BUFS-1:0] GATED_MODE = '0
) (
	input wire logic clock,
	input wire logic nrst,
	input wire clock_mux_pkg::chan_in_t chan_in [NUM_BUFS],
	output logic [NUM_BUFS-1:0] clk_out,
	output logic [NUM_BUFS-1:0] src_active
);

	// Edge of a sampled clock into the given level
	function automatic logic edge_to(input logic now, input logic was, input logic level);
		return (now == level) && (was != level);
	endfunction : edge_to

	clock_mux_pkg::path_state_t state_q [NUM_BUFS];
	clock_mux_pkg::path_state_t state_d [NUM_BUFS];
	logic [NUM_BUFS-1:0] src_q;
	logic [NUM_BUFS-1:0] src_d;
	logic [NUM_BUFS-1:0] out_q;
	logic [NUM_BUFS-1:0] out_d;
	logic [NUM_BUFS-1:0] samp0_q;
	logic [NUM_BUFS-1:0] samp0_d;
	logic [NUM_BUFS-1:0] samp1_q;
	logic [NUM_BUFS-1:0] samp1_d;

	logic [NUM_BUFS-1:0] want_src;
	logic [NUM_BUFS-1:0] want_run;
	logic [NUM_BUFS-1:0] cur_in;
	logic [NUM_BUFS-1:0] cur_was;
	logic [NUM_BUFS-1:0] new_in;
	logic [NUM_BUFS-1:0] new_was;
	logic [NUM_BUFS-1:0] pending;
	logic [NUM_BUFS-1:0] drain_edge;
	logic [NUM_BUFS-1:0] start_edge;

	for (genvar i = 0; i < NUM_BUFS; i++) begin : g_chan
		// gated mode uses src0 and the enable
		assign want_src[i] = GATED_MODE[i] ? 1'h0 : chan_in[i].sel;
		assign want_run[i] = GATED_MODE[i] ? chan_in[i].ce : 1'h1;
		assign cur_in[i] = src_q[i] ? chan_in[i].src1 : chan_in[i].src0;
		assign cur_was[i] = src_q[i] ? samp1_q[i] : samp0_q[i];
		assign new_in[i] = want_src[i] ? chan_in[i].src1 : chan_in[i].src0;
		assign new_was[i] = want_src[i] ? samp1_q[i] : samp0_q[i];
		// a change is pending while select differs from the owner or, in gated mode, the enable is low
		assign pending[i] = (want_src[i] != src_q[i]) || !want_run[i];
		assign drain_edge[i] = edge_to(cur_in[i], cur_was[i], STOP_HIGH[i]);
		assign start_edge[i] = edge_to(new_in[i], new_was[i], !STOP_HIGH[i]);
	end

	// Next state of every channel
	always_comb begin
		samp0_d = '0;
		samp1_d = '0;
		src_d = src_q;
		out_d = out_q;
		for (int i = 0; i < NUM_BUFS; i++) begin
			samp0_d[i] = chan_in[i].src0;
			samp1_d[i] = chan_in[i].src1;
			state_d[i] = state_q[i];
			case (state_q[i])
				// output follows the live source only
				clock_mux_pkg::ST_RUN: begin
					out_d[i] = cur_in[i];
					// park on old clock entering stop level
					if (pending[i] && drain_edge[i]) begin
						out_d[i] = STOP_HIGH[i];
						state_d[i] = clock_mux_pkg::ST_PARK;
					end
				end
				clock_mux_pkg::ST_PARK: begin
					out_d[i] = STOP_HIGH[i];
					src_d[i] = want_src[i];
					// release on new clock leaving stop level
					if (want_run[i] && start_edge[i]) begin
						out_d[i] = new_in[i];
						state_d[i] = clock_mux_pkg::ST_RUN;
					end
				end
				default: begin
					out_d[i] = STOP_HIGH[i];
					state_d[i] = clock_mux_pkg::ST_PARK;
				end
			endcase
		end
	end

	// Channel registers
	always_ff @(posedge clock) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_BUFS; i++) begin
				state_q[i] <= clock_mux_pkg::STATE_RESET;
			end
			src_q <= {NUM_BUFS{clock_mux_pkg::SRC_RESET}};
			out_q <= STOP_HIGH;
			samp0_q <= STOP_HIGH;
			samp1_q <= STOP_HIGH;
		end else begin
			for (int i = 0; i < NUM_BUFS; i++) begin
				state_q[i] <= state_d[i];
			end
			src_q <= src_d;
			out_q <= out_d;
			samp0_q <= samp0_d;
			samp1_q <= samp1_d;
		end
	end

	// Outputs straight from flops
	assign clk_out = out_q;
	assign src_active = src_q;

	// Checks per channel
	for (genvar i = 0; i < NUM_BUFS; i++) begin : g_chk
		chk_out_follows_src: assert property (
			@(posedge clock) disable iff (!nrst)
			(state_q[i] == clock_mux_pkg::ST_RUN) |=> (clk_out[i] == $past(cur_in[i])))
			else $error("running output does not follow its source");
		chk_park_stop_level: assert property (
			@(posedge clock) disable iff (!nrst)
			(state_q[i] == clock_mux_pkg::ST_PARK) |-> (clk_out[i] == STOP_HIGH[i]))
			else $error("parked output is not at stop level");
		chk_no_early_drop: assert property (
			@(posedge clock) disable iff (!nrst)
			(state_q[i] == clock_mux_pkg::ST_RUN && !drain_edge[i])
			|=> (state_q[i] == clock_mux_pkg::ST_RUN))
			else $error("output parked without an edge into stop level");
		chk_drain_on_edge: assert property (
			@(posedge clock) disable iff (!nrst)
			(state_q[i] == clock_mux_pkg::ST_RUN && pending[i] && drain_edge[i])
			|=> (state_q[i] == clock_mux_pkg::ST_PARK) && (clk_out[i] == STOP_HIGH[i]))
			else $error("pending change not parked on old clock edge");
		chk_release_on_edge: assert property (
			@(posedge clock) disable iff (!nrst)
			(state_q[i] == clock_mux_pkg::ST_PARK && want_run[i] && start_edge[i])
			|=> (state_q[i] == clock_mux_pkg::ST_RUN) && (clk_out[i] != STOP_HIGH[i])
			&& (src_active[i] == $past(want_src[i])))
			else $error("release not on new clock edge");
		chk_gate_source: assert property (
			@(posedge clock) disable iff (!nrst)
			GATED_MODE[i] |-> ##1 (src_active[i] == 1'h0))
			else $error("gated channel left input 0");
		chk_gate_holds: assert property (
			@(posedge clock) disable iff (!nrst)
			(GATED_MODE[i] && state_q[i] == clock_mux_pkg::ST_PARK && !chan_in[i].ce)
			|=> (state_q[i] == clock_mux_pkg::ST_PARK))
			else $error("gated channel ran with enable low");
		chk_channel_alone: assert property (
			@(posedge clock) disable iff (!nrst)
			($changed(clk_out[i]) && $past(state_q[i] == clock_mux_pkg::ST_RUN))
			|-> (clk_out[i] == $past(cur_in[i])))
			else $error("channel output moved without its own source");

		// Guards on ownership, output edges, reset and restart
		chk_src_held_run: assert property (
			@(posedge clock) disable iff (!nrst)
			(state_q[i] == clock_mux_pkg::ST_RUN) |=> (src_active[i] == $past(src_active[i])))
			else $error("source owner changed while running");
		chk_edge_from_source: assert property (
			@(posedge clock) disable iff (!nrst)
			$changed(clk_out[i])
			|-> ($past(cur_in[i] != cur_was[i]) || $past(new_in[i] != new_was[i])))
			else $error("output moved without a source edge");
		chk_park_retarget: assert property (
			@(posedge clock) disable iff (!nrst)
			(state_q[i] == clock_mux_pkg::ST_PARK) |=> (src_active[i] == $past(want_src[i])))
			else $error("parked channel did not take new select");
		chk_reset_parks: assert property (
			@(posedge clock)
			!nrst |=> (state_q[i] == clock_mux_pkg::ST_PARK) && (clk_out[i] == STOP_HIGH[i])
			&& (src_active[i] == 1'h0))
			else $error("reset did not park the channel");
		chk_gate_restarts: assert property (
			@(posedge clock) disable iff (!nrst)
			(GATED_MODE[i] && state_q[i] == clock_mux_pkg::ST_PARK && chan_in[i].ce
			&& start_edge[i]) |=> (state_q[i] == clock_mux_pkg::ST_RUN))
			else $error("gated channel missed its restart edge");
		chk_mux_restarts: assert property (
			@(posedge clock) disable iff (!nrst)
			(!GATED_MODE[i] && state_q[i] == clock_mux_pkg::ST_PARK && start_edge[i])
			|=> (state_q[i] == clock_mux_pkg::ST_RUN))
			else $error("selector missed the new clock edge");

		cov_switch_done: cover property (
			@(posedge clock) disable iff (!nrst)
			(state_q[i] == clock_mux_pkg::ST_PARK) ##1 (state_q[i] == clock_mux_pkg::ST_RUN)
			&& $changed(src_active[i]));
		cov_park: cover property (
			@(posedge clock) disable iff (!nrst)
			(state_q[i] == clock_mux_pkg::ST_RUN) ##1 (state_q[i] == clock_mux_pkg::ST_PARK));
		cov_gate_restart: cover property (
			@(posedge clock) disable iff (!nrst)
			GATED_MODE[i] && $rose(chan_in[i].ce)
			##[1:20] (state_q[i] == clock_mux_pkg::ST_RUN));
		cov_retarget: cover property (
			@(posedge clock) disable iff (!nrst)
			(state_q[i] == clock_mux_pkg::ST_PARK) && $changed(src_active[i])
			##1 (state_q[i] == clock_mux_pkg::ST_PARK) && $changed(src_active[i]));
		cov_gate_stop: cover property (
			@(posedge clock) disable iff (!nrst)
			GATED_MODE[i] && $fell(chan_in[i].ce)
			##[1:20] (state_q[i] == clock_mux_pkg::ST_PARK));
	end

endmodule : glitch_free_clock_selector

// file: source_clock_model.sv
// Two free-running source clocks shared by every channel
`timescale 1ns/100ps

module source_clock_model #(
	parameter int HALF0 = 4,
	parameter int HALF1 = 7
) (
	input wire logic clock,
	output logic src0,
	output logic src1
);
	int n0 = 0;
	int n1 = 0;
	// two unrelated clocks, no tie to select
	initial begin
		src0 = 1'h0;
		src1 = 1'h0;
		forever begin
			@(posedge clock);
			#1;
			n0 = (n0 + 1) % HALF0;
			n1 = (n1 + 1) % HALF1;
			src0 = (n0 == 0) ? ~src0 : src0;
			src1 = (n1 == 0) ? ~src1 : src1;
		end
	end
endmodule : source_clock_model

// file: tb_top.sv
// Self-checking bench for the clock selector bank
`timescale 1ns/100ps

module tb_top;
	logic clock = 1'h0;
	logic nrst = 1'h0;
	logic src0;
	logic src1;
	logic s0_q;
	logic s1_q;
	logic [15:0] sel_v = 16'h0;
	logic [15:0] ce_v = 16'hffff;
	logic [15:0] clk_out;
	logic [15:0] src_active;
	logic [15:0] last;
	clock_mux_pkg::chan_in_t chan_in [16];
	int run [16];
	int failures = 0;
	int checks_done = 0;
	// Clock and watchdog
	initial begin
		forever #25 clock = ~clock;
	end
	initial begin
		#100000;
		failures++;
		stop_test();
	end
	source_clock_model partner (.clock(clock), .src0(src0), .src1(src1));
	glitch_free_clock_selector #(.NUM_BUFS(16), .STOP_HIGH(16'haaaa),
		.GATED_MODE(16'hcccc)) dut (.clock(clock), .nrst(nrst), .chan_in(chan_in),
		.clk_out(clk_out), .src_active(src_active));
	// Channel bundles and source levels seen at each edge
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			chan_in[i] = '{src0, src1, sel_v[i], ce_v[i]};
		end
	end
	always @(posedge clock) begin
		s0_q <= src0;
		s1_q <= src1;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Flags output pulses shorter than a source half period
	always @(negedge clock) begin
		for (int i = 0; i < 16; i++) begin
			if (!nrst) begin
				run[i] = 8;
			end else if (clk_out[i] !== last[i]) begin
				if (run[i] < 3) check(16'(run[i]), 16'h3);
				run[i] = 0;
			end else begin
				run[i]++;
			end
			last[i] = clk_out[i];
		end
	end
	task automatic drive(input logic [15:0] s, input logic [15:0] c);
		@(posedge clock);
		#1;
		sel_v = s;
		ce_v = c;
	endtask : drive
	// Settles, then follows the expected output for n cycles
	task automatic watch(input int n);
		logic [15:0] exp;
		repeat (16) @(negedge clock);
		repeat (n) begin
			@(negedge clock);
			exp = ((sel_v[0] ? {16{s1_q}} : {16{s0_q}}) & 16'h3333)
				| ((ce_v[2] ? {16{s0_q}} : 16'haaaa) & 16'hcccc);
			check(clk_out, exp);
		end
	endtask : watch
	task automatic await_src(input logic [15:0] want);
		int k;
		k = 0;
		while (src_active !== want && k < 40) begin
			@(negedge clock);
			k++;
		end
		check(src_active, want);
	endtask : await_src
	task automatic t_reset;
		repeat (11) @(negedge clock);
		check(clk_out, 16'haaaa);
		check(src_active, 16'h0);
		@(posedge clock);
		#1;
		nrst = 1'h1;
	endtask : t_reset
	task automatic t_switch;
		drive(16'hffff, 16'hffff);
		await_src(16'h3333);
		watch(24);
		drive(16'h0, 16'hffff);
		drive(16'hffff, 16'hffff);
		drive(16'h0, 16'hffff);
		await_src(16'h0);
		watch(24);
	endtask : t_switch
	task automatic t_gate;
		drive(16'h0, 16'h0);
		watch(24);
		drive(16'h0, 16'hffff);
		watch(24);
	endtask : t_gate
	task automatic stop_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		t_reset();
		watch(24);
		t_switch();
		t_gate();
		stop_test();
	end
endmodule : tb_top
